// ### hdl/trigger_delay_average_sequencer.sv
// trigger conditioning, measure/trigger delays and moving average
// assumes trig_in synchronous to ref_clk; samples arrive from the core
`timescale 1ns/1ps
`default_nettype none
module trigger_delay_average_sequencer
	import seq_pkg::*;
#(
	parameter int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * CYC_PER_MS,
	parameter int unsigned MS_CYC       = CYC_PER_MS
)
(
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        trig_in,
	input  wire sample_t     sample_in,
	output var  logic        meas_start,
	output var  sample_t     result_out
);
	// refuse timing the counters cannot hold; the coarse measure delay
	// multiplies MS_CYC by the 0.1 s step inside a 32-bit counter
	if (DEBOUNCE_CYC < 1 || MS_CYC < 1 ||
		64'(MS_CYC) * 64'(MDLY_FINE_MS) > 64'hFFFF_FFFF)
		$error("timing parameters out of range for the cycle counters");

	////////////////////////////////////////////////////////////////////
	// register file
	cfg_t        cfg;
	logic        aw_held;
	logic        w_held;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        avg_restart;
	logic [31:0] ctrl_word;
	logic [31:0] mdly_word;
	logic [31:0] tdly_word;
	logic [31:0] wr_word;
	logic        next_aw_held;
	logic        next_w_held;
	logic        next_bvalid;
	logic        next_rvalid;

	assign ctrl_word = {17'h0_0000, cfg.avg_count, 4'h0, cfg.falling,
		cfg.tdly_en, cfg.mdly_en, cfg.avg_en};
	assign mdly_word = {15'h0000, cfg.mdly_ms};
	assign tdly_word = {22'h00_0000, cfg.tdly_ms};

	// capture address and data in either order, answer once both are in
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (aw_held && w_held && !s_axi_bvalid)
			begin
				aw_held <= 1'b0;
				w_held  <= 1'b0;
			end
		end
	end

	// ready flags are registered from the next held/answer state, so the
	// outputs come from flops yet still match the state of each cycle
	assign next_aw_held = (aw_held && !(w_held && !s_axi_bvalid))
		|| (s_axi_awvalid && s_axi_awready);
	assign next_w_held  = (w_held && !(aw_held && !s_axi_bvalid))
		|| (s_axi_wvalid && s_axi_wready);
	assign next_bvalid  = (aw_held && w_held && !s_axi_bvalid)
		|| (s_axi_bvalid && !s_axi_bready);

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end
		else
		begin
			s_axi_awready <= !next_aw_held && !next_bvalid;
			s_axi_wready  <= !next_w_held && !next_bvalid;
		end
	end

	// merge byte lanes over the current value of the target register
	function automatic logic [31:0] merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[i*8 +: 8] = new_v[i*8 +: 8];
		return r;
	endfunction

	always_comb
	begin
		case (aw_addr)
			ADDR_CTRL: wr_word = merge(ctrl_word, w_data, w_strb);
			ADDR_MDLY: wr_word = merge(mdly_word, w_data, w_strb);
			ADDR_TDLY: wr_word = merge(tdly_word, w_data, w_strb);
			default:   wr_word = 32'h0000_0000;
		endcase
	end

	// out-of-range settings are clamped, save MDLY bits above 16 and CTRL bits above 14, which are
	// dropped; the block never runs outside its documented span
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cfg.avg_en    <= CTRL_RESET[CTRL_AVG_EN];
			cfg.mdly_en   <= CTRL_RESET[CTRL_MDLY_EN];
			cfg.tdly_en   <= CTRL_RESET[CTRL_TDLY_EN];
			cfg.falling   <= CTRL_RESET[CTRL_FALLING];
			cfg.avg_count <= CTRL_RESET[CTRL_CNT_LSB +: 7];
			cfg.mdly_ms   <= 17'h0_0000;
			cfg.tdly_ms   <= 10'h000;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			avg_restart   <= 1'b0;
		end
		else
		begin
			avg_restart <= 1'b0;
			if (aw_held && w_held && !s_axi_bvalid)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= RESP_OKAY;
				case (aw_addr)
					ADDR_CTRL:
					begin
						cfg.avg_en  <= wr_word[CTRL_AVG_EN];
						cfg.mdly_en <= wr_word[CTRL_MDLY_EN];
						cfg.tdly_en <= wr_word[CTRL_TDLY_EN];
						cfg.falling <= wr_word[CTRL_FALLING];
						if (wr_word[CTRL_CNT_LSB +: 7] < 7'(AVG_MIN))
							cfg.avg_count <= 7'(AVG_MIN);
						else if (wr_word[CTRL_CNT_LSB +: 7] > 7'(AVG_MAX))
							cfg.avg_count <= 7'(AVG_MAX);
						else
							cfg.avg_count <= wr_word[CTRL_CNT_LSB +: 7];
						avg_restart <= 1'b1;
					end
					ADDR_MDLY:
						if (wr_word[16:0] > 17'(MDLY_MAX_MS))
							cfg.mdly_ms <= 17'(MDLY_MAX_MS);
						else
							cfg.mdly_ms <= wr_word[16:0];
					ADDR_TDLY:
						if (wr_word[9:0] > 10'(TDLY_MAX_MS) ||
							wr_word[31:10] != 22'h00_0000)
							cfg.tdly_ms <= 10'(TDLY_MAX_MS);
						else
							cfg.tdly_ms <= wr_word[9:0];
					default:
						s_axi_bresp <= RESP_SLVERR;
				endcase
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// read channel: one read at a time, data latched with the address
	assign next_rvalid = (s_axi_arvalid && s_axi_arready)
		|| (s_axi_rvalid && !s_axi_rready);

	// reserved and unmapped offsets answer with an error and zero data
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end
		else
		begin
			s_axi_rvalid  <= next_rvalid;
			s_axi_arready <= !next_rvalid;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rresp <= RESP_OKAY;
				case (s_axi_araddr)
					ADDR_CTRL: s_axi_rdata <= ctrl_word;
					ADDR_MDLY: s_axi_rdata <= mdly_word;
					ADDR_TDLY: s_axi_rdata <= tdly_word;
					default:
					begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= RESP_SLVERR;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// trigger path
	typedef enum {T_IDLE, T_WINDOW, T_DELAY} trig_state_t;
	trig_state_t   tstate;
	logic          trig_prev;
	logic [31:0]   cyc_cnt;
	logic [16:0]   ms_left;
	logic          trig_fire;
	logic          edge_seen;

	// the active edge, found from the raw input against its copy registered one cycle earlier
	assign edge_seen = cfg.falling ? (trig_prev && !trig_in)
		: (!trig_prev && trig_in);

	// any change of level inside the window drops back to T_IDLE, so a bouncing
	// contact is never taken as a trigger
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			tstate    <= T_IDLE;
			trig_prev <= 1'b0;
			cyc_cnt   <= 32'h0000_0000;
			ms_left   <= 17'h0_0000;
			trig_fire <= 1'b0;
		end
		else
		begin
			trig_prev <= trig_in;
			trig_fire <= 1'b0;
			case (tstate)
				T_IDLE:
					if (edge_seen)
					begin
						tstate  <= T_WINDOW;
						cyc_cnt <= 32'h0000_0000;
					end
				T_WINDOW:
					if (trig_prev != trig_in)
						tstate <= T_IDLE;
					else if (cyc_cnt == DEBOUNCE_CYC - 1)
					begin
						cyc_cnt <= 32'h0000_0000;
						if (cfg.tdly_en && cfg.tdly_ms != 10'h000)
						begin
							tstate  <= T_DELAY;
							ms_left <= {7'h00, cfg.tdly_ms};
						end
						else
						begin
							tstate    <= T_IDLE;
							trig_fire <= 1'b1;
						end
					end
					else
						cyc_cnt <= cyc_cnt + 32'h0000_0001;
				T_DELAY:
					if (cyc_cnt == MS_CYC - 1)
					begin
						cyc_cnt <= 32'h0000_0000;
						if (ms_left == 17'h0_0001)
						begin
							tstate    <= T_IDLE;
							trig_fire <= 1'b1;
						end
						ms_left <= ms_left - 17'h0_0001;
					end
					else
						cyc_cnt <= cyc_cnt + 32'h0000_0001;
				default:
					tstate <= T_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// measure delay between trigger and measurement start
	logic          mdly_busy;
	logic [31:0]   mcyc;
	logic [16:0]   mleft;
	logic [16:0]   mstep;

	// coarse settings advance in 0.1 s steps, so the low digits drop out
	assign mstep = (cfg.mdly_ms < 17'(MDLY_FINE_MS)) ? 17'h0_0001
		: 17'(MDLY_FINE_MS);

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			mdly_busy  <= 1'b0;
			mcyc       <= 32'h0000_0000;
			mleft      <= 17'h0_0000;
			meas_start <= 1'b0;
		end
		else
		begin
			meas_start <= 1'b0;
			if (!mdly_busy)
			begin
				if (trig_fire && cfg.mdly_en
					&& cfg.mdly_ms >= mstep)
				begin
					mdly_busy <= 1'b1;
					mcyc      <= 32'h0000_0000;
					mleft     <= cfg.mdly_ms / mstep;
				end
				else if (trig_fire)
					meas_start <= 1'b1;
			end
			else if (mcyc == MS_CYC * 32'(mstep) - 1)
			begin
				mcyc <= 32'h0000_0000;
				mleft <= mleft - 17'h0_0001;
				if (mleft == 17'h0_0001)
				begin
					mdly_busy  <= 1'b0;
					meas_start <= 1'b1;
				end
			end
			else
				mcyc <= mcyc + 32'h0000_0001;
		end
	end

	////////////////////////////////////////////////////////////////////
	// moving average over the last avg_count samples
	localparam int unsigned SUM_W = SAMPLE_W + 7;
	logic [SAMPLE_W-1:0] hist [AVG_MAX];
	logic [6:0]          wptr;
	logic [6:0]          fill;
	logic [SUM_W-1:0]    sum;
	logic [SUM_W-1:0]    next_sum;
	logic [SAMPLE_W-1:0] oldest;

	// ring of the last avg_count samples; a running sum avoids re-adding
	assign oldest   = hist[wptr];
	assign next_sum = sum + SUM_W'(sample_in.value)
		- ((fill == cfg.avg_count) ? SUM_W'(oldest) : SUM_W'(0));

	always_ff @(posedge ref_clk)
	begin
		if (sample_in.valid)
			hist[wptr] <= sample_in.value;
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wptr       <= 7'h00;
			fill       <= 7'h00;
			sum        <= '0;
			result_out <= '0;
		end
		else if (avg_restart || !cfg.avg_en)
		begin
			wptr       <= 7'h00;
			fill       <= 7'h00;
			sum        <= '0;
			// a sample meeting a restart passes raw, never lost
			result_out.valid <= sample_in.valid;
			result_out.value <= sample_in.value;
		end
		else
		begin
			result_out.valid <= sample_in.valid;
			if (sample_in.valid)
			begin
				sum  <= next_sum;
				wptr <= (wptr == cfg.avg_count - 7'h01) ? 7'h00
					: wptr + 7'h01;
				if (fill != cfg.avg_count)
					fill <= fill + 7'h01;
				// until the ring fills, the mean covers what has arrived
				result_out.value <= SAMPLE_W'(next_sum /
					((fill == cfg.avg_count) ? SUM_W'(fill)
					: SUM_W'(fill + 7'h01)));
			end
		end
	end
endmodule
`default_nettype wire

// ### hdl/seq_pkg.sv
// constants, register map and carrier types of the measurement sequencer
// assumes a 100 MHz ref_clk and an AXI4-Lite master with 32-bit data
package seq_pkg;
	localparam int unsigned CLK_HZ        = 100_000_000;
	localparam int unsigned MS_PER_S      = 1000;
	localparam int unsigned CYC_PER_MS    = CLK_HZ / MS_PER_S;
	localparam int unsigned MS_COUNT_W    = 17;
	localparam int unsigned DEBOUNCE_MS   = 10;
	localparam int unsigned MDLY_MAX_MS   = 100_000;
	localparam int unsigned MDLY_FINE_MS  = 100;
	localparam int unsigned TDLY_MAX_MS   = 1000;
	localparam int unsigned AVG_MIN       = 2;
	localparam int unsigned AVG_MAX       = 100;
	localparam int unsigned SAMPLE_W      = 24;
	// register byte addresses
	localparam logic [7:0] ADDR_CTRL  = 8'h00;
	localparam logic [7:0] ADDR_MDLY  = 8'h04;
	localparam logic [7:0] ADDR_TDLY  = 8'h08;
	localparam logic [7:0] ADDR_STAT  = 8'h0C;
	localparam logic [7:0] ADDR_RESULT = 8'h10;
	// control fields
	localparam int unsigned CTRL_AVG_EN   = 0;
	localparam int unsigned CTRL_MDLY_EN  = 1;
	localparam int unsigned CTRL_TDLY_EN  = 2;
	localparam int unsigned CTRL_FALLING  = 3;
	localparam int unsigned CTRL_CNT_LSB  = 8;
	localparam logic [31:0] CTRL_RESET    = 32'h0000_0200;
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef struct packed {
		logic        avg_en;
		logic        mdly_en;
		logic        tdly_en;
		logic        falling;
		logic [6:0]  avg_count;
		logic [16:0] mdly_ms;
		logic [9:0]  tdly_ms;
	} cfg_t;

	typedef struct packed {
		logic                valid;
		logic [SAMPLE_W-1:0] value;
	} sample_t;
endpackage

// ### dv/seq_props.sv
// port checker for the measurement sequencer
// bound onto every sequencer instance, see the foot of this file
`timescale 1ns/1ps
`default_nettype none
module seq_props
	import seq_pkg::*;
#(
	parameter int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * CYC_PER_MS,
	parameter int unsigned MS_CYC       = CYC_PER_MS
)
(
	input wire logic    ref_clk,
	input wire logic    resetn,
	input wire logic    s_axi_awvalid,
	input wire logic    s_axi_awready,
	input wire logic    s_axi_wvalid,
	input wire logic    s_axi_wready,
	input wire logic    s_axi_bvalid,
	input wire logic    s_axi_bready,
	input wire logic    s_axi_arvalid,
	input wire logic    s_axi_arready,
	input wire logic    s_axi_rvalid,
	input wire logic    s_axi_rready,
	input wire logic    trig_in,
	input wire sample_t sample_in,
	input wire logic    meas_start,
	input wire sample_t result_out
);
	logic       trig_q;
	logic [7:0] calm;
	// quiet time of trig_in; saturates so that long idles stay legal
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			calm <= 8'h00;
		else if (trig_in != trig_q)
			calm <= 8'h00;
		else if (calm != 8'hff)
			calm <= calm + 8'h01;
	end
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			trig_q <= 1'b0;
		else
			trig_q <= trig_in;
	end
	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);
	// write channel handshake
	b_hold_a: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bresp lost");
	aw_refuse_a: assert property (
		s_axi_bvalid |-> !s_axi_awready) else $error("aw taken early");
	w_refuse_a: assert property (
		s_axi_bvalid |-> !s_axi_wready) else $error("w taken early");
	b_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid) else $error("no bresp");
	// read channel handshake
	r_hold_a: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rdata lost");
	ar_refuse_a: assert property (
		s_axi_rvalid |-> !s_axi_arready) else $error("ar taken early");
	r_answer_a: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no rdata");
	// sample path and trigger path
	res_follow_a: assert property (
		sample_in.valid |=> result_out.valid) else $error("result missing");
	res_cause_a: assert property (
		result_out.valid |-> $past(sample_in.valid)) else $error("stray result");
	start_pulse_a: assert property (
		meas_start |=> !meas_start) else $error("start too long");
	debounce_a: assert property (
		meas_start |-> calm + 8'd2 >= DEBOUNCE_CYC) else $error("bounce start");
endmodule
bind trigger_delay_average_sequencer seq_props #(
	.DEBOUNCE_CYC(DEBOUNCE_CYC),
	.MS_CYC(MS_CYC)
) u_props (
	.ref_clk, .resetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .trig_in, .sample_in,
	.meas_start, .result_out
);
`default_nettype wire

// ### dv/trig_handler.sv
// model of the outside handler that drives the trigger line
// busy stays high until the line has reached its final level
`timescale 1ns/1ps
`default_nettype none
module trig_handler
(
	input wire logic       ref_clk,
	input wire logic       go,
	input wire logic       level,
	input wire logic [3:0] bounces,
	input wire logic [3:0] gap,
	output var logic       trig_in,
	output var logic       busy
);
	logic [4:0] left = 5'h00;
	logic [3:0] wait_c = 4'h0;
	initial trig_in = 1'b0;
	assign busy = left != 5'h00;
	// a bounce is a pair of toggles; a gap under the window models chatter
	always @(posedge ref_clk)
	begin
		if (go)
		begin
			left <= {bounces, 1'b0} + 5'(level != trig_in);
			wait_c <= gap;
		end
		else if (busy && wait_c != 4'h0)
			wait_c <= wait_c - 4'h1;
		else if (busy)
		begin
			trig_in <= !trig_in;
			left <= left - 5'h01;
			wait_c <= gap;
		end
	end
endmodule
`default_nettype wire

// ### dv/tb_top.sv
// self-checking bench for the measurement sequencer
// one queue of expectations serves results, write and read answers
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import seq_pkg::*;
;
	localparam int DEB = 8;
	localparam int MSC = 4;
	logic ref_clk, resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, meas_start, trig_in;
	logic go, lvl, busy;
	logic s_axi_arvalid, s_axi_rready, s_axi_arready, s_axi_rvalid;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb, nb, gp;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [23:0] lf;
	sample_t sample_in, result_out;
	int err_count, comparisons, starts, cyc, last;
	logic [31:0] exp_q[$];
	int dv[6] = '{0, 3, 2000, 5, 150, 200};
	int dl[6] = '{0, 3*MSC, 1000*MSC, 5*MSC, 100*MSC, 200*MSC};
	int av[11] = '{3, 9, 6, 12, 30, 60, 90, 120, 8, 4, 2};
	int ae[11] = '{3, 6, 6, 9, 30, 45, 60, 90, 8, 6, 3};
	logic [31:0] ac[3] = '{32'h0000_0301, 32'h0000_0501, 32'h0000_0101};
	logic [3:0] as[3] = '{4'hf, 4'h1, 4'hf};
	trigger_delay_average_sequencer #(.DEBOUNCE_CYC(DEB), .MS_CYC(MSC)) uut (
		.ref_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .trig_in,
		.sample_in, .meas_start, .result_out);
	trig_handler hnd (.ref_clk, .go, .level(lvl), .bounces(nb), .gap(gp),
		.trig_in, .busy);
	////////////////////////////////////////////////////////////////
	initial
	begin
		ref_clk = 1'b0;
		forever
			#5 ref_clk = ~ref_clk;
	end
	// watchdog sized well above the longest delay run
	initial
	begin
		repeat (40000)
			@(posedge ref_clk);
		err_count++;
		results();
	end
	always @(posedge ref_clk)
		cyc <= cyc + 1;
	// output watcher: starts are stamped, results and responses checked
	always @(negedge ref_clk)
	begin
		if (meas_start === 1'b1)
		begin
			starts++;
			last = cyc;
		end
		if (result_out.valid === 1'b1)
			chk({8'h00, result_out.value}, exp_q.pop_front());
		if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
			chk({30'h0, s_axi_bresp}, exp_q.pop_front());
		if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
		begin
			chk(s_axi_rdata, exp_q.pop_front());
			chk({30'h0, s_axi_rresp}, exp_q.pop_front());
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	function automatic logic [23:0] lfsr(input logic [23:0] v);
		return {v[22:0], v[23] ^ v[22] ^ v[21] ^ v[16]};
	endfunction
	task automatic send(input logic [23:0] v, input logic [23:0] e);
		exp_q.push_back({8'h00, e});
		sample_in <= {1'b1, v};
		@(posedge ref_clk);
		sample_in.valid <= 1'b0;
		@(posedge ref_clk);
	endtask
	// aw and w may be taken on different edges; each drops once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [1:0] r);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		exp_q.push_back({30'h0, r});
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_ok && w_ok))
		begin
			@(negedge ref_clk);
			aw_ok = aw_ok || s_axi_awready === 1'b1;
			w_ok = w_ok || s_axi_wready === 1'b1;
			@(posedge ref_clk);
			s_axi_awvalid <= !aw_ok;
			s_axi_wvalid <= !w_ok;
		end
		do
		begin
			@(negedge ref_clk);
			aw_ok = s_axi_bvalid === 1'b1;
			@(posedge ref_clk);
		end
		while (!aw_ok);
		// bready stays up: lowering it would clash with the next raise
	endtask
	// read: address held until taken, data and response checked on rvalid
	task automatic rd(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		logic ok;
		ok = 1'b0;
		exp_q.push_back(d);
		exp_q.push_back({30'h0, r});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(negedge ref_clk);
			ok = s_axi_arready === 1'b1;
			@(posedge ref_clk);
		end
		while (!ok);
		s_axi_arvalid <= 1'b0;
		do
		begin
			@(negedge ref_clk);
			ok = s_axi_rvalid === 1'b1;
			@(posedge ref_clk);
		end
		while (!ok);
	endtask
	// e is the nominal start latency after settling; negative: no start
	task automatic fire(input logic l, input logic [3:0] b, input logic [3:0] g,
		input int e);
		int t0;
		int s0;
		s0 = starts;
		lvl <= l;
		nb <= b;
		gp <= g;
		go <= 1'b1;
		@(posedge ref_clk);
		go <= 1'b0;
		do
			@(negedge ref_clk);
		while (busy);
		t0 = cyc;
		repeat ((e < 0 ? 40 : e) + 12)
			@(negedge ref_clk);
		chk(starts - s0, e >= 0);
		if (e >= 0)
			chk(last - t0 inside {[e:e+5]} ? e : last - t0, e);
		@(posedge ref_clk);
	endtask
	task automatic results;
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// main sequence
	initial
	begin
		{resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, go, lvl} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_araddr} = '0;
		{s_axi_awaddr, s_axi_wdata, s_axi_wstrb, nb, gp, sample_in} = '0;
		{cyc, starts, last, err_count, comparisons} = '0;
		lf = 24'h1_47da;
		repeat (8)
			@(posedge ref_clk);
		resetn <= 1'b1;
		@(posedge ref_clk);
		rd(ADDR_CTRL, CTRL_RESET, RESP_OKAY);
		repeat (3)
		begin
			lf = lfsr(lf);
			send(lf, lf);
		end
		fire(1'b1, 4'h2, 4'h2, DEB);
		fire(1'b0, 4'h0, 4'h5, -1);
		fire(1'b0, 4'h1, 4'h2, -1);
		wr(ADDR_CTRL, 32'h0000_0208, 4'hf, RESP_OKAY);
		fire(1'b1, 4'h0, 4'h2, -1);
		fire(1'b0, 4'h0, 4'h2, DEB);
		for (int i = 0; i < 6; i++)
		begin
			wr(i < 3 ? ADDR_TDLY : ADDR_MDLY, dv[i], 4'hf, RESP_OKAY);
			wr(ADDR_CTRL, i < 3 ? 32'h0000_020c : 32'h0000_020a, 4'hf,
				RESP_OKAY);
			fire(1'b1, 4'h0, 4'h2, -1);
			fire(1'b0, 4'h0, 4'h2, DEB + dl[i]);
		end
		rd(ADDR_TDLY, 32'(TDLY_MAX_MS), RESP_OKAY);
		rd(ADDR_MDLY, dv[5], RESP_OKAY);
		for (int i = 0; i < 11; i++)
		begin
			if (i % 4 == 0)
				wr(ADDR_CTRL, ac[i/4], as[i/4], RESP_OKAY);
			send(av[i], ae[i]);
		end
		rd(ADDR_CTRL, 32'h0000_0201, RESP_OKAY);
		wr(ADDR_CTRL, 32'h0000_6401, 4'hf, RESP_OKAY);
		for (int k = 1; k <= 101; k++)
			send(2 * k, k <= 100 ? k + 1 : 103);
		wr(8'h14, 32'h0000_0000, 4'hf, RESP_SLVERR);
		rd(8'h14, 32'h0000_0000, RESP_SLVERR);
		results();
	end
endmodule
`default_nettype wire
